/* prm_chan.sv */
// One upstream channel: T3/T4 timers, inhibit and usability tracking
`timescale 1ns/1ps
`include "prm_consts.svh"

module prm_chan #(
  parameter int unsigned T3_CYC = `PRM_T3_CYCLES,
  parameter int unsigned T4_CYC = `PRM_T4_CYCLES
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             enable,
  input  wire logic [7:0]       retry_limit,
  // Events for this channel
  input  wire logic             opp,
  input  wire logic             sent,
  input  wire logic             rsp_valid,
  input  wire prm_pkg::prm_rsp_t rsp,
  input  wire logic             reconfig,
  input  wire logic             greconfig,
  // Channel state
  output logic                  inhibit,
  output logic                  unusable,
  output logic                  suspended,
  output logic                  apply,
  output logic                  t3_exp,
  output logic                  t4_exp
);

  prm_pkg::prm_chan_st_t st_q;      // Handshake state
  logic [31:0]           t3_cnt_q;  // Response wait counter
  logic [31:0]           t4_cnt_q;  // Opportunity wait counter
  logic [7:0]            fails_q;   // T3 expiries since last response
  logic                  global_q;  // Adjustment waits for global time
  logic                  t4_dead_q; // T4 already fired, wait for opp
  logic                  t3_hit;
  logic                  t4_hit;
  logic                  apply_hit;

  assign t3_hit    = (st_q == prm_pkg::st_wait_rsp) &&
                     (t3_cnt_q == T3_CYC - 1);
  assign t4_hit    = enable && !t4_dead_q && !opp &&
                     (t4_cnt_q == T4_CYC - 1);
  assign apply_hit = (st_q == prm_pkg::st_wait_apply) &&
                     (global_q ? greconfig : reconfig);
  assign inhibit   = (st_q != prm_pkg::st_idle);

  // Maintenance timer restarts on every opportunity for this channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t4_cnt_q  <= 32'h0000_0000;
      t4_dead_q <= 1'b0;
    end else if (!enable || opp) begin // [R18]
      t4_cnt_q  <= 32'h0000_0000;
      t4_dead_q <= 1'b0;
    end else if (t4_hit) begin
      t4_dead_q <= 1'b1;
    end else if (!t4_dead_q) begin
      t4_cnt_q  <= t4_cnt_q + 32'h0000_0001;
    end
  end

  // Send, wait for response or T3, then wait for the adjustment
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= prm_pkg::st_idle;
      t3_cnt_q <= 32'h0000_0000;
      global_q <= 1'b0;
    end else begin
      case (st_q)
        prm_pkg::st_idle: begin
          t3_cnt_q <= 32'h0000_0000;
          if (enable && sent) begin
            st_q <= prm_pkg::st_wait_rsp; // [R6]
          end
        end
        prm_pkg::st_wait_rsp: begin
          t3_cnt_q <= t3_cnt_q + 32'h0000_0001;
          if (rsp_valid) begin
            st_q     <= prm_pkg::st_wait_apply; // [R7]
            global_q <= rsp.drw_adj;            // [R12]
          end else if (t3_hit) begin
            st_q <= prm_pkg::st_idle; // [R6]
          end
        end
        prm_pkg::st_wait_apply: begin
          if (apply_hit) begin
            st_q <= prm_pkg::st_idle; // [R7]
          end
        end
        default: st_q <= prm_pkg::st_idle;
      endcase
    end
  end

  // T3 expiry count, usability and suspension
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fails_q   <= 8'h00;
      unusable  <= 1'b0;
      suspended <= 1'b0;
    end else begin
      if (rsp_valid && st_q == prm_pkg::st_wait_rsp) begin
        fails_q <= 8'h00; // [R18]
      end else if (t3_hit && fails_q != 8'hFF) begin
        fails_q <= fails_q + 8'h01;
      end
      if (t4_hit || (t3_hit && fails_q >= retry_limit)) begin
        unusable <= 1'b1; // [R9]
      end else if (rsp_valid && rsp.success) begin
        unusable <= 1'b0;
      end
      if (rsp_valid && rsp.cont) begin
        suspended <= 1'b1; // [R13]
      end else if (rsp_valid && rsp.success) begin
        suspended <= 1'b0; // [R13]
      end
    end
  end

  // One-cycle event pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      apply  <= 1'b0;
      t3_exp <= 1'b0;
      t4_exp <= 1'b0;
    end else begin
      apply  <= apply_hit; // [R12]
      t3_exp <= t3_hit && !rsp_valid;
      t4_exp <= t4_hit;
    end
  end

endmodule : prm_chan

/* prm_consts.svh */
// Register offsets, field positions, reset values and timing figures
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH

// Register byte offsets on the bus
`define PRM_OFS_CTRL      8'h00
`define PRM_OFS_PRIMARY   8'h04
`define PRM_OFS_RETRY     8'h08
`define PRM_OFS_STATUS    8'h0C
`define PRM_OFS_IRQ_STAT  8'h10
`define PRM_OFS_IRQ_MASK  8'h14

// Control register fields
`define PRM_CTRL_ENABLE   0
`define PRM_CTRL_MULTI    1
`define PRM_CTRL_REINIT_ACK 2

// Status register field positions
`define PRM_ST_UNUSABLE   0
`define PRM_ST_SUSPEND    8
`define PRM_ST_INHIBIT    16
`define PRM_ST_PARTIAL    24
`define PRM_ST_REINIT     25
`define PRM_ST_REASON     26

// Interrupt bit positions
`define PRM_IRQ_T4        0
`define PRM_IRQ_T3        1
`define PRM_IRQ_UNUSABLE  2
`define PRM_IRQ_REINIT    3
`define PRM_IRQ_BITS      4

// Reset values
`define PRM_RST_CTRL      2'h0
`define PRM_RST_PRIMARY   8'h01
`define PRM_RST_RETRY     8'h10
`define PRM_RST_IRQ_MASK  4'h0

// Timing: clock rate and timer lengths in milliseconds
`define PRM_CLK_KHZ       40000
`define PRM_T3_MS         200
`define PRM_T4_MS         30000
`define PRM_T3_CYCLES     (`PRM_T3_MS * `PRM_CLK_KHZ)
`define PRM_T4_CYCLES     (`PRM_T4_MS * `PRM_CLK_KHZ)

`endif

/* prm_headend_model.sv */
// Headend scheduler plus modem send stub facing the block
`timescale 1ns/1ps
module prm_headend_model #(
  parameter int unsigned PER = 40  // Grant spacing, well inside T4
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Scenario controls
  input  wire logic [7:0]    grant_en,
  input  wire logic          answer,
  input  wire logic          cont,
  input  wire logic [3:0]    rdly,
  // Block state
  input  wire logic [7:0]    rng_inhibit,
  // Events towards the block
  output logic [7:0]         maint_opp,
  output logic [7:0]         rng_sent,
  output logic               rsp_valid,
  output prm_pkg::prm_rsp_t  rsp_info,
  output logic               reconfig_time,
  output logic               global_reconfig_time
);
  logic [7:0] per_q;   // Grant spacing counter
  logic [4:0] cnt_q;   // Answer delay counter
  logic       pend_q;  // Request awaiting an answer

  // Grants, sends, answers and reconfiguration ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {maint_opp, rng_sent, rsp_valid, rsp_info} <= 23'h000000;
      {reconfig_time, global_reconfig_time, per_q} <= 10'h000;
      {cnt_q, pend_q} <= 6'h00;
    end else begin
      {maint_opp, rng_sent, rsp_valid} <= 17'h00000;
      rsp_info <= ~rsp_info;  // No stale content between answers
      per_q <= per_q + 8'h01;
      reconfig_time <= (per_q[1:0] == 2'h3);
      global_reconfig_time <= (per_q[2:0] == 3'h7);
      if (per_q == 8'(PER - 1)) begin
        per_q <= 8'h00;
        maint_opp <= grant_en;
      end
      // Send on a channel 0 opportunity only while allowed
      if (maint_opp[0] && !rng_inhibit[0] && !pend_q) begin
        rng_sent[0] <= 1'b1;
        pend_q <= 1'b1;
        cnt_q <= {1'b0, rdly};
      end
      // One request outstanding; answer after the delay
      if (pend_q) begin
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h00) begin
          pend_q <= 1'b0;
          if (answer) begin
            rsp_valid <= 1'b1;
            rsp_info <= {3'h0, cont, !cont, rdly[0]};
            if (cont) begin
              per_q <= 8'(PER - 10);
            end
          end
        end
      end
    end
  end
endmodule : prm_headend_model

/* prm_maint.sv */
// Periodic ranging maintenance: channel trackers, reinit and AHB registers
// Functional notes
// (R1) Headend grants ranging each channel per T4
// (R2) Headend spaces grants to survive lost map
// (R3) Headend gives OFDMA opportunity per indicator per T4
// (R4) Headend may add ranging when probes selected
// (R5) Headend avoids grants soon after response
// (R6) After sending, inhibit until response or T3
// (R7) Keep inhibiting until response adjustments applied
// (R8) Single channel: T4 expiry reinitialises with timeout
// (R9) Multi channel: T4 or excess T3 marks unusable
// (R10) No usable primary channel: reinit, no-primary reason
// (R11) Usable primary channel left: never reinitialise
// (R12) Apply adjustments at first (global) reconfiguration time
// (R13) Continue status suspends data until success
// (R14) Headend sends continue only when reception uncertain
// (R15) Headend quickly reschedules after continue
// (R16) Headend may speed maintenance in code-division mode
// (R17) Headend defers grants during pending-till-complete
// (R18) Per-channel T3, T4 timers and expiry counters
`timescale 1ns/1ps
`include "prm_consts.svh"

module prm_maint #(
  parameter int unsigned NCH    = 8,
  parameter int unsigned T3_CYC = `PRM_T3_CYCLES,
  parameter int unsigned T4_CYC = `PRM_T4_CYCLES
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // Upstream MAC events
  input  wire logic [NCH-1:0]   maint_opp,
  input  wire logic [NCH-1:0]   rng_sent,
  input  wire logic             rsp_valid,
  input  wire prm_pkg::prm_rsp_t rsp_info,
  input  wire logic             reconfig_time,
  input  wire logic             global_reconfig_time,
  // Per-channel state towards the MAC
  output logic [NCH-1:0]        rng_inhibit,
  output logic [NCH-1:0]        data_block,
  output logic [NCH-1:0]        adjust_apply,
  // Reinitialisation and service state
  output logic                  reinit_req,
  output prm_pkg::prm_reason_t  reinit_reason,
  output logic                  partial_service,
  // Interrupt
  output logic                  irq
);

  // Register a byte offset against a decoded address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Software-visible control
  logic [1:0]            ctrl_q;      // Enable and multi-channel mode
  logic [NCH-1:0]        primary_q;   // Channels of the primary flow
  logic [7:0]            retry_q;     // Invited ranging retry limit
  logic [`PRM_IRQ_BITS-1:0] irq_st_q; // Sticky event bits
  logic [`PRM_IRQ_BITS-1:0] irq_mk_q; // Interrupt enables

  // Bus pipeline
  logic                  wr_q;        // Data phase holds a write
  logic [7:0]            wa_q;        // Offset of the pending write
  logic                  acc;         // Address phase accepted
  logic                  rd_acc;
  logic                  irq_rd;      // Read of the event register

  // Channel tracker outputs
  logic [NCH-1:0]        ch_inh;
  logic [NCH-1:0]        ch_unu;
  logic [NCH-1:0]        ch_sus;
  logic [NCH-1:0]        ch_app;
  logic [NCH-1:0]        ch_t3;
  logic [NCH-1:0]        ch_t4;
  logic [NCH-1:0]        ch_rsp;
  logic [NCH-1:0]        unu_prev_q;  // Last cycle's unusable bits

  // Reinit decision
  logic                  reinit_pend_q; // Held until software acks
  logic                  need_t4;
  logic                  need_prim;
  logic [`PRM_IRQ_BITS-1:0] ev;
  logic [31:0]           status;
  logic [31:0]           rdata;

  assign acc    = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign irq_rd = rd_acc && hit(haddr[7:0], `PRM_OFS_IRQ_STAT);

  // Route the single response to the channel it names
  always_comb begin
    ch_rsp = '0;
    if (rsp_valid && rsp_info.chan < NCH) begin
      ch_rsp[rsp_info.chan] = 1'b1;
    end
  end

  // One tracker per upstream channel
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      prm_chan #(
        .T3_CYC (T3_CYC),
        .T4_CYC (T4_CYC)
      ) u_chan (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .enable      (ctrl_q[`PRM_CTRL_ENABLE]),
        .retry_limit (retry_q),
        .opp         (maint_opp[gi]),
        .sent        (rng_sent[gi]),
        .rsp_valid   (ch_rsp[gi]),
        .rsp         (rsp_info),
        .reconfig    (reconfig_time),
        .greconfig   (global_reconfig_time),
        .inhibit     (ch_inh[gi]),
        .unusable    (ch_unu[gi]),
        .suspended   (ch_sus[gi]),
        .apply       (ch_app[gi]),
        .t3_exp      (ch_t3[gi]),
        .t4_exp      (ch_t4[gi])
      );
    end
  endgenerate

  // Single channel mode: channel 0 timing out T4 forces a reinit
  assign need_t4 = !ctrl_q[`PRM_CTRL_MULTI] && ch_t4[0]; // [R8]

  // Multi mode: reinit only once every primary channel is unusable
  assign need_prim = ctrl_q[`PRM_CTRL_MULTI] && (primary_q != '0) &&
                     ((ch_unu & primary_q) == primary_q); // [R10] [R11]

  // Reinit request pulse, reason and pending latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reinit_pend_q <= 1'b0;
      reinit_req    <= 1'b0;
      reinit_reason <= prm_pkg::reason_none;
    end else begin
      reinit_req <= 1'b0;
      if (!reinit_pend_q && need_t4) begin
        reinit_pend_q <= 1'b1;
        reinit_req    <= 1'b1; // [R8]
        reinit_reason <= prm_pkg::maintenance_timeout_reason;
      end else if (!reinit_pend_q && need_prim) begin
        reinit_pend_q <= 1'b1;
        reinit_req    <= 1'b1; // [R10]
        reinit_reason <= prm_pkg::no_primary_flow_upstream_reason;
      end else if (wr_q && hit(wa_q, `PRM_OFS_CTRL) &&
                   hwdata[`PRM_CTRL_REINIT_ACK]) begin
        reinit_pend_q <= 1'b0;
        reinit_reason <= prm_pkg::reason_none;
      end
    end
  end

  // Registered per-channel outputs towards the MAC
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rng_inhibit     <= '0;
      data_block      <= '0;
      adjust_apply    <= '0;
      partial_service <= 1'b0;
      unu_prev_q      <= '0;
    end else begin
      rng_inhibit     <= ch_inh;          // [R6] [R7]
      data_block      <= ch_sus | ch_unu; // [R13] [R9]
      adjust_apply    <= ch_app;          // [R12]
      partial_service <= ctrl_q[`PRM_CTRL_MULTI] && (ch_unu != '0); // [R9]
      unu_prev_q      <= ch_unu;
    end
  end

  // Events that set sticky interrupt bits
  always_comb begin
    ev = '0;
    ev[`PRM_IRQ_T4]       = |ch_t4;
    ev[`PRM_IRQ_T3]       = |ch_t3;
    ev[`PRM_IRQ_UNUSABLE] = |(ch_unu & ~unu_prev_q);
    ev[`PRM_IRQ_REINIT]   = reinit_req;
  end

  // Sticky status: a read clears, a new event in that cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_q <= (irq_rd ? '0 : irq_st_q) | ev;
      irq      <= |(((irq_rd ? '0 : irq_st_q) | ev) & irq_mk_q);
    end
  end

  // Bus pipeline: capture write address in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (hready) begin
      wr_q <= acc && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  // Software-written control registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `PRM_RST_CTRL;
      primary_q <= NCH'(`PRM_RST_PRIMARY);
      retry_q   <= `PRM_RST_RETRY;
      irq_mk_q  <= `PRM_RST_IRQ_MASK;
    end else if (wr_q) begin
      if (hit(wa_q, `PRM_OFS_CTRL)) begin
        ctrl_q <= hwdata[1:0];
      end
      if (hit(wa_q, `PRM_OFS_PRIMARY)) begin
        primary_q <= hwdata[NCH-1:0];
      end
      if (hit(wa_q, `PRM_OFS_RETRY)) begin
        retry_q <= hwdata[7:0];
      end
      if (hit(wa_q, `PRM_OFS_IRQ_MASK)) begin
        irq_mk_q <= hwdata[`PRM_IRQ_BITS-1:0];
      end
    end
  end

  // Status word showing live channel state
  always_comb begin
    status = 32'h0000_0000;
    status[`PRM_ST_UNUSABLE +: NCH] = ch_unu;
    status[`PRM_ST_SUSPEND  +: NCH] = ch_sus;
    status[`PRM_ST_INHIBIT  +: NCH] = ch_inh;
    status[`PRM_ST_PARTIAL]         = partial_service;
    status[`PRM_ST_REINIT]          = reinit_pend_q;
    status[`PRM_ST_REASON +: 2]     = reinit_reason;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[7:0])
      `PRM_OFS_CTRL:     rdata[1:0] = ctrl_q;
      `PRM_OFS_PRIMARY:  rdata[NCH-1:0] = primary_q;
      `PRM_OFS_RETRY:    rdata[7:0] = retry_q;
      `PRM_OFS_STATUS:   rdata = status;
      `PRM_OFS_IRQ_STAT: rdata[`PRM_IRQ_BITS-1:0] = irq_st_q;
      `PRM_OFS_IRQ_MASK: rdata[`PRM_IRQ_BITS-1:0] = irq_mk_q;
      default:           rdata = 32'h0000_0000;
    endcase
  end

  // Read data captured at the address phase, shown in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1; // Zero wait states
      hresp     <= 1'b0; // Always OKAY
      if (rd_acc) begin
        hrdata <= rdata;
      end
    end
  end

endmodule : prm_maint

/* prm_maint_monitor.sv */
// Port checker for the periodic ranging maintenance block
`timescale 1ns/1ps
module prm_maint_monitor #(
  parameter int unsigned NCH    = 8,
  parameter int unsigned T3_CYC = 20,
  parameter int unsigned T4_CYC = 100
) (
  // Clock and reset
  input wire logic                 hclk,
  input wire logic                 hresetn,
  // MAC events
  input wire logic [NCH-1:0]       maint_opp,
  input wire logic [NCH-1:0]       rng_sent,
  input wire logic                 rsp_valid,
  input wire prm_pkg::prm_rsp_t    rsp_info,
  input wire logic                 reconfig_time,
  input wire logic                 global_reconfig_time,
  // Block outputs
  input wire logic [NCH-1:0]       rng_inhibit,
  input wire logic [NCH-1:0]       data_block,
  input wire logic [NCH-1:0]       adjust_apply,
  input wire logic                 reinit_req,
  input wire prm_pkg::prm_reason_t reinit_reason,
  input wire logic                 partial_service
);
  localparam int unsigned T3_LO = T3_CYC - 4; // Slack for launch stages
  logic [31:0] inh_q;  // Cycles channel 0 stayed inhibited
  logic [31:0] opp_q;  // Cycles since channel 0 opportunity
  logic [5:0]  rc_q;   // Recent reconfiguration times
  logic [5:0]  suc_q;  // Recent success answers on channel 0

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Event history of channel 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inh_q <= 32'h0;
      opp_q <= 32'h0;
      rc_q  <= 6'h0;
      suc_q <= 6'h0;
    end else begin
      inh_q <= rng_inhibit[0] ? inh_q + 32'h1 : 32'h0;
      opp_q <= maint_opp[0] ? 32'h0 : opp_q + 32'h1;
      rc_q  <= {rc_q[4:0], reconfig_time | global_reconfig_time};
      suc_q <= {suc_q[4:0], rsp_valid & rsp_info.success
                & (rsp_info.chan == 3'h0)};
    end
  end

  property p_inh_rise;
    $rose(rng_inhibit[0]) |-> $past(rng_sent[0]) || $past(rng_sent[0], 2)
      || $past(rng_sent[0], 3);
  endproperty
  a_inh_rise: assert property (p_inh_rise)
    else $error("inhibit rose without a send");
  property p_inh_hold;
    $fell(rng_inhibit[0]) |-> adjust_apply[0] || $past(adjust_apply[0])
      || inh_q >= T3_LO;
  endproperty
  a_inh_hold: assert property (p_inh_hold)
    else $error("inhibit dropped early");
  property p_apply_rc;
    adjust_apply[0] |-> rc_q != 6'h0;
  endproperty
  a_apply_rc: assert property (p_apply_rc)
    else $error("adjust outside reconfiguration time");
  property p_cont;
    rsp_valid && rsp_info.cont && rsp_info.chan == 3'h0
      |-> ##[1:4] data_block[0];
  endproperty
  a_cont: assert property (p_cont)
    else $error("continue did not block data");
  property p_susp;
    $fell(data_block[0]) |-> suc_q != 6'h0;
  endproperty
  a_susp: assert property (p_susp)
    else $error("block lifted without success");
  property p_reinit_t4;
    reinit_req && reinit_reason == prm_pkg::maintenance_timeout_reason
      |-> opp_q >= T4_CYC;
  endproperty
  a_reinit_t4: assert property (p_reinit_t4)
    else $error("timeout reinit before T4");
  // Assumes channel 0 is the sole primary channel whenever a no-primary reinit fires
  property p_reinit_prim;
    reinit_req && reinit_reason == prm_pkg::no_primary_flow_upstream_reason
      |-> data_block[0] || $past(data_block[0]);
  endproperty
  a_reinit_prim: assert property (p_reinit_prim)
    else $error("reinit with primary channel usable");
  property p_reinit_pulse;
    reinit_req |=> !reinit_req;
  endproperty
  a_reinit_pulse: assert property (p_reinit_pulse)
    else $error("reinit request longer than one cycle");
  property p_partial;
    partial_service |-> (|data_block) || (|$past(data_block));
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial service with no blocked channel");
endmodule : prm_maint_monitor

bind prm_maint prm_maint_monitor #(
  .NCH(NCH), .T3_CYC(T3_CYC), .T4_CYC(T4_CYC)
) prm_maint_monitor_inst (.*);

/* prm_pkg.sv */
// Types shared by the periodic ranging maintenance block
package prm_pkg;

  // Per-channel ranging handshake state
  typedef enum logic [1:0] {
    st_idle,
    st_wait_rsp,
    st_wait_apply
  } prm_chan_st_t;

  // Reason code given with a MAC reinitialisation request
  typedef enum logic [1:0] {
    reason_none,
    maintenance_timeout_reason,
    no_primary_flow_upstream_reason
  } prm_reason_t;

  // Contents of one received ranging response
  typedef struct packed {
    logic [2:0] chan;      // Upstream channel index
    logic       cont;      // Ranging status continue
    logic       success;   // Ranging status success
    logic       drw_adj;   // Dynamic range window adjustment carried
  } prm_rsp_t;

endpackage : prm_pkg

/* tb.sv */
// Self-checking bench for the periodic ranging maintenance block
`timescale 1ns/1ps
module tb;
  logic                 hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [7:0]           maint_opp, rng_sent, rng_inhibit, grant_en;
  logic [7:0]           data_block, adjust_apply;
  logic                 rsp_valid, reconfig_time, global_reconfig_time;
  logic                 reinit_req, partial_service, irq;
  logic                 answer, cont, rd_dp, ck_irq;
  logic [3:0]           rdly;
  prm_pkg::prm_rsp_t    rsp_info;
  prm_pkg::prm_reason_t reinit_reason;
  logic [31:0]          eq[$], mq[$];  // Expected values and masks
  string                nq[$];         // Names of the checked items
  int                   err_total, n_compared;

  prm_maint #(.NCH(8), .T3_CYC(20), .T4_CYC(100)) prm_maint_inst (
    .hready(hreadyout), .*);
  prm_headend_model prm_headend_model_inst (.*);

  // Clock of 25 ns
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Random answer delay for the headend model
  always @(posedge hclk) rdly <= 4'($urandom_range(15, 1));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // Oldest note is compared when a read or an irq sample appears
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      chk(nq.pop_front(), eq.pop_front(), hrdata & mq.pop_front());
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (ck_irq)
      chk(nq.pop_front(), eq.pop_front(), {31'h0, irq} & mq.pop_front());
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic rst();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : rst
  // One AHB-Lite single transfer; reads note the expected value
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m, input string n);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
      nq.push_back(n);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    rd_dp <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 32'h0, 32'h0, "");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string n);
    bus(1'b0, a, 32'h0, e, m, n);
  endtask : rd
  task automatic pin(input logic e);
    @(posedge hclk);
    ck_irq <= 1'b1;
    eq.push_back({31'h0, e});
    mq.push_back(32'h1);
    nq.push_back("irq");
    @(posedge hclk);
    ck_irq <= 1'b0;
  endtask : pin

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge hclk);
    err_total++;
    $display("ERROR watchdog exp finish got hang");
    stop_test();
  end

  // Main sequence
  initial begin
    {hsel, hwrite, rd_dp, ck_irq, answer, cont} = 6'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    grant_en = 8'h00;
    hresetn = 1'b0;
    void'($urandom(88));
    rst();
    rd(8'h00, 32'h0, 32'h7, "ctrl");
    rd(8'h04, 32'h1, 32'hFF, "primary");
    rd(8'h08, 32'h10, 32'hFF, "retry");
    rd(8'h14, 32'h0, 32'hF, "irq_mask");
    wr(8'h40, $urandom());
    rd(8'h40, 32'h0, 32'hFFFFFFFF, "unmapped");
    wr(8'h08, {24'h0, 8'($urandom())} | 32'h1);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h1, 32'hFF, "retry");
    $display("test registers done");
    grant_en <= 8'hFF;
    answer <= 1'b1;
    wr(8'h00, 32'h1);
    repeat (300) @(posedge hclk);
    rd(8'h0C, 32'h0, 32'h0F00FFFF, "status");
    rd(8'h10, 32'h0, 32'hF, "irq_status");
    cont <= 1'b1;
    repeat (100) @(posedge hclk);
    rd(8'h0C, 32'h100, 32'h100, "suspend");
    cont <= 1'b0;
    repeat (100) @(posedge hclk);
    rd(8'h0C, 32'h0, 32'h100, "suspend");
    $display("test answered ranging done");
    rst();
    answer <= 1'b0;
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h3);
    repeat (200) @(posedge hclk);
    rd(8'h0C, 32'h01000001, 32'h0F000001, "status");
    wr(8'h04, 32'h1);
    repeat (5) @(posedge hclk);
    rd(8'h0C, 32'h0B000001, 32'h0F000001, "status");
    pin(1'b0);
    wr(8'h14, 32'h8);
    pin(1'b1);
    rd(8'h10, 32'hE, 32'hE, "irq_status");
    pin(1'b0);
    $display("test retry exhaustion done");
    rst();
    answer <= 1'b1;
    grant_en <= 8'h00;
    wr(8'h14, 32'h1);
    wr(8'h00, 32'h1);
    repeat (130) @(posedge hclk);
    rd(8'h0C, 32'h06000000, 32'h0E000000, "status");
    pin(1'b1);
    rd(8'h10, 32'h9, 32'h9, "irq_status");
    pin(1'b0);
    $display("test single timeout done");
    rst();
    grant_en <= 8'hFE;
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h3);
    repeat (150) @(posedge hclk);
    rd(8'h0C, 32'h01000001, 32'h0F000003, "status");
    $display("test multi timeout done");
    stop_test();
  end
endmodule : tb
